// >>> iscs_pkg.sv
/*
 * Package for the integer shift, compare and halfword store slice.
 * Assumes one core clock and a synchronous active-low reset.
 */
package iscs_pkg;

	// ----------------------------------------
	// Widths and instruction fields
	// ----------------------------------------
	localparam int WORD_W = 32;
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int SRC_HI = 25;
	localparam int SRC_LO = 21;
	localparam int TGT_HI = 20;
	localparam int TGT_LO = 16;
	localparam int DST_HI = 15;
	localparam int DST_LO = 11;
	localparam int SHAMT_HI = 10;
	localparam int SHAMT_LO = 6;
	localparam int FUNCT_HI = 5;
	localparam int IMM_HI = 15;
	localparam int EVA_OFF_HI = 15;
	localparam int EVA_OFF_LO = 7;
	localparam int EVA_FUNCT_HI = 5;
	localparam int SHCNT_W = 5;

	// ----------------------------------------
	// Opcode and function encodings
	// ----------------------------------------
	localparam logic [5:0] OPC_SPECIAL = 6'h00;
	localparam logic [5:0] OPC_SETLT_IMM = 6'h0a;
	localparam logic [5:0] OPC_SETLTU_IMM = 6'h0b;
	localparam logic [5:0] OPC_SHW = 6'h29;
	localparam logic [5:0] OPC_SPECIAL3 = 6'h1f;
	localparam logic [5:0] FN_SHL = 6'h00;
	localparam logic [5:0] FN_SHLV = 6'h04;
	localparam logic [5:0] FN_SETLT = 6'h2a;
	localparam logic [5:0] FN_SETLTU = 6'h2b;
	localparam logic [5:0] FN_HALF_USER = 6'h1d;
	localparam logic [4:0] SHAMT_SSNOP = 5'h01;

	// ----------------------------------------
	// Segment access modes
	// ----------------------------------------
	localparam logic [2:0] SEG_UNMAP_USER = 3'h1;
	localparam logic [2:0] SEG_MAP_USER_SUP = 3'h2;
	localparam logic [2:0] SEG_MAP_USER_KERN = 3'h3;

	typedef enum {
		OP_NONE,
		OP_SHL,
		OP_SHLV,
		OP_LT_S,
		OP_LT_U,
		OP_LT_S_IMM,
		OP_LT_U_IMM,
		OP_ST_HALF,
		OP_ST_USER
	} iscs_op_e;

	typedef struct packed {
		logic valid;
		logic [31:0] instr;
		logic [31:0] srcVal;
		logic [31:0] tgtVal;
		logic kernelMode;
		logic [2:0] segMode;
	} iscs_issue_s;

	typedef struct packed {
		logic valid;
		logic [4:0] dest;
		logic [31:0] value;
	} iscs_wb_s;

	typedef struct packed {
		logic valid;
		logic [31:0] vaddr;
		logic [31:0] data;
		logic [3:0] byteEn;
		logic userMap;
	} iscs_store_s;

	typedef struct packed {
		logic addrErr;
		logic resInstr;
		logic issueBreak;
	} iscs_exc_s;

endpackage

// >>> iscs_shifter.sv
/*
 * Left logical shifter and less-than comparator.
 * Assumes operands are stable for the cycle in which they are used.
 */
`timescale 1ns/1ps
module iscs_shifter
	import iscs_pkg::*;
#(
	parameter int W = WORD_W
) (
	// Operands
	input wire logic [W-1:0] opA,
	input wire logic [W-1:0] opB,
	input wire logic [SHCNT_W-1:0] shiftCount,
	// Results
	output logic [W-1:0] shifted,
	output logic lessSigned,
	output logic lessUnsigned
);
	// Zero fill from the right
	assign shifted = opB << shiftCount;
	// Plain compares never trap
	assign lessSigned = $signed(opA) < $signed(opB);
	assign lessUnsigned = opA < opB;
endmodule

// >>> iscs_lane_steer.sv
/*
 * Halfword lane steering for stores.
 * Assumes a 32-bit little-lane memory word with four byte strobes.
 */
`timescale 1ns/1ps
module iscs_lane_steer
	import iscs_pkg::*;
(
	// Inputs
	input wire logic addrBit1,
	input wire logic bigEndian,
	input wire logic endianSwap,
	input wire logic [15:0] half,
	// Outputs
	output logic [31:0] laneData,
	output logic [3:0] laneEn
);
	logic upper;
	// Big-endian and swap each flip the lane
	assign upper = addrBit1 ^ bigEndian ^ endianSwap;
	assign laneData = upper ? {half, 16'h0000} : {16'h0000, half};
	assign laneEn = upper ? 4'hc : 4'h3;
endmodule

// >>> iscs_unit.sv
/*
 * Integer shift, set-less-than and halfword store slice, one stage deep.
 * Assumes decode hands over operand values and privilege state each cycle.
 */
`timescale 1ns/1ps
module iscs_unit
	import iscs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration
	input wire logic enhancedVaddrPresentBit,
	input wire logic bigEndianConfig,
	input wire logic endianSwapMode,
	// Issue
	input wire iscs_issue_s issue,
	// Results
	output iscs_wb_s wbOut,
	output iscs_store_s storeOut,
	output iscs_exc_s excOut
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic iscs_op_e decodeOp(input logic [31:0] ins);
		iscs_op_e op;
		op = OP_NONE;
		case (ins[OPC_HI:OPC_LO])
			OPC_SPECIAL: begin
				case (ins[FUNCT_HI:0])
					FN_SHL: op = OP_SHL;
					FN_SHLV: op = OP_SHLV;
					FN_SETLT: op = OP_LT_S;
					FN_SETLTU: op = OP_LT_U;
					default: op = OP_NONE;
				endcase
			end
			OPC_SETLT_IMM: op = OP_LT_S_IMM;
			OPC_SETLTU_IMM: op = OP_LT_U_IMM;
			OPC_SHW: op = OP_ST_HALF;
			OPC_SPECIAL3: begin
				if (ins[EVA_FUNCT_HI:0] == FN_HALF_USER && ins[6] == 1'b0) begin
					op = OP_ST_USER;
				end else begin
					op = OP_NONE;
				end
			end
			default: op = OP_NONE;
		endcase
		return op;
	endfunction

	iscs_op_e op;
	logic [4:0] srcIdx;
	logic [4:0] tgtIdx;
	logic [4:0] dstIdx;
	logic [4:0] shamt;
	logic [31:0] immSext;
	logic [31:0] eaStd;
	logic [31:0] eaUser;
	logic [31:0] ea;
	logic isStore;
	logic isCompare;
	logic isShift;
	logic userStAllowed;
	logic misaligned;
	logic isNopIdiom;
	logic isBreakIdiom;

	assign op = issue.valid ? decodeOp(issue.instr) : OP_NONE;
	assign srcIdx = issue.instr[SRC_HI:SRC_LO];
	assign tgtIdx = issue.instr[TGT_HI:TGT_LO];
	assign dstIdx = issue.instr[DST_HI:DST_LO];
	assign shamt = issue.instr[SHAMT_HI:SHAMT_LO];
	assign immSext = {{16{issue.instr[IMM_HI]}}, issue.instr[IMM_HI:0]};

	// ----------------------------------------
	// Address generation
	// ----------------------------------------
	assign eaStd = issue.srcVal + immSext;
	assign eaUser = issue.srcVal
		+ {{23{issue.instr[EVA_OFF_HI]}}, issue.instr[EVA_OFF_HI:EVA_OFF_LO]};
	assign ea = (op == OP_ST_USER) ? eaUser : eaStd;
	assign misaligned = ea[0];
	assign userStAllowed = enhancedVaddrPresentBit && issue.kernelMode
		&& (issue.segMode == SEG_UNMAP_USER || issue.segMode == SEG_MAP_USER_SUP
		|| issue.segMode == SEG_MAP_USER_KERN);

	assign isStore = (op == OP_ST_HALF) || (op == OP_ST_USER && userStAllowed);
	assign isCompare = (op == OP_LT_S) || (op == OP_LT_U) || (op == OP_LT_S_IMM)
		|| (op == OP_LT_U_IMM);
	assign isShift = (op == OP_SHL) || (op == OP_SHLV);

	// Idioms need zero tgtIdx and dstIdx and write nothing back
	assign isNopIdiom = (op == OP_SHL) && tgtIdx == 5'h00 && dstIdx == 5'h00
		&& shamt == 5'h00;
	assign isBreakIdiom = (op == OP_SHL) && tgtIdx == 5'h00 && dstIdx == 5'h00
		&& shamt == SHAMT_SSNOP;

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	logic immForm;
	logic [31:0] cmpB;
	logic [SHCNT_W-1:0] shiftCnt;
	logic [31:0] shiftRes;
	logic ltS;
	logic ltU;
	logic cmpBit;
	logic [31:0] laneData;
	logic [3:0] laneEn;

	assign immForm = (op == OP_LT_S_IMM) || (op == OP_LT_U_IMM);
	assign cmpB = immForm ? immSext : issue.tgtVal;
	assign shiftCnt = (op == OP_SHLV) ? issue.srcVal[SHCNT_W-1:0] : shamt;

	iscs_shifter #(
		.W(WORD_W)
	) u_shift (
		.opA(issue.srcVal),
		.opB(isShift ? issue.tgtVal : cmpB),
		.shiftCount(shiftCnt),
		.shifted(shiftRes),
		.lessSigned(ltS),
		.lessUnsigned(ltU)
	);

	assign cmpBit = (op == OP_LT_U || op == OP_LT_U_IMM) ? ltU : ltS;

	iscs_lane_steer u_lane (
		.addrBit1(ea[1]),
		.bigEndian(bigEndianConfig),
		.endianSwap(endianSwapMode),
		.half(issue.tgtVal[15:0]),
		.laneData(laneData),
		.laneEn(laneEn)
	);

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	iscs_wb_s nxt_wb;
	iscs_store_s nxt_store;
	iscs_exc_s nxt_exc;

	always_comb begin
		nxt_wb = '0;
		if (isCompare) begin
			nxt_wb.valid = 1'b1;
			nxt_wb.dest = immForm ? tgtIdx : dstIdx;
			nxt_wb.value = {31'h00000000, cmpBit};
		end else if (isShift && !isNopIdiom && !isBreakIdiom) begin
			nxt_wb.valid = 1'b1;
			nxt_wb.dest = dstIdx;
			nxt_wb.value = shiftRes;
		end
	end

	always_comb begin
		nxt_store = '0;
		if (isStore && !misaligned) begin
			nxt_store.valid = 1'b1;
			nxt_store.vaddr = ea;
			nxt_store.data = laneData;
			nxt_store.byteEn = laneEn;
			nxt_store.userMap = (op == OP_ST_USER) && issue.segMode == SEG_MAP_USER_KERN;
		end
	end

	// Compares never flag overflow; no overflow output exists
	always_comb begin
		nxt_exc = '0;
		nxt_exc.addrErr = isStore && misaligned;
		nxt_exc.resInstr = (op == OP_ST_USER) && !userStAllowed;
		nxt_exc.issueBreak = isBreakIdiom;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	iscs_wb_s wb_ff;
	iscs_store_s store_ff;
	iscs_exc_s exc_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wb_ff <= '0;
			store_ff <= '0;
			exc_ff <= '0;
		end else begin
			wb_ff <= nxt_wb;
			store_ff <= nxt_store;
			exc_ff <= nxt_exc;
		end
	end

	assign wbOut = wb_ff;
	assign storeOut = store_ff;
	assign excOut = exc_ff;
endmodule

// >>> iscs_mem_model.sv
/* Memory side model: byte-lane sink for halfword stores.
 Assumes stores arrive one cycle wide, never stalled. */
`timescale 1ns/1ps
module iscs_mem_model
	import iscs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Store request
	input wire iscs_store_s store
);
	logic [7:0] mem [256];
	always @(posedge clk) begin
		if (rst_n && store.valid) begin
			for (int b = 0; b < 4; b++) begin
				if (store.byteEn[b]) begin
					mem[{store.vaddr[7:2], 2'(b)}] <= store.data[8*b +: 8];
				end
			end
		end
	end
endmodule

// >>> iscs_unit_sva.sv
/* Port checker for the unit.
 Assumes one clock and synchronous active-low reset. */
`timescale 1ns/1ps
module iscs_unit_chk
	import iscs_pkg::*;
(
	// Clock, reset, config
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enhancedVaddrPresentBit,
	input wire logic bigEndianConfig,
	input wire logic endianSwapMode,
	// Watched ports
	input wire iscs_issue_s issue,
	input wire iscs_wb_s wbOut,
	input wire iscs_store_s storeOut,
	input wire iscs_exc_s excOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire [31:0] imm = {{16{issue.instr[15]}}, issue.instr[15:0]};
	wire [31:0] ea = issue.srcVal + imm;
	wire [31:0] ea9 = issue.srcVal + {{23{issue.instr[15]}}, issue.instr[15:7]};
	wire [5:0] opc = issue.instr[31:26];
	wire ltu = issue.srcVal < imm;
	wire lts = $signed(issue.srcVal) < $signed(imm);
	wire up = ea[1] ^ bigEndianConfig ^ endianSwapMode;
	wire isHalfStore = issue.valid && opc == OPC_SHW;
	wire isUserStore = issue.valid && opc == OPC_SPECIAL3
		&& issue.instr[6:0] == {1'b0, FN_HALF_USER};
	a_ltu_imm_result: assert property (
		issue.valid && opc == OPC_SETLTU_IMM |=> wbOut.valid
		&& wbOut.dest == $past(issue.instr[20:16]) && wbOut.value == {31'h0, $past(ltu)})
		else $error("unsigned immediate compare wrong");
	a_lt_imm_result: assert property (
		issue.valid && opc == OPC_SETLT_IMM |=> wbOut.value == {31'h0, $past(lts)})
		else $error("signed immediate compare wrong");
	a_store_odd: assert property (
		isHalfStore && ea[0] |=> excOut.addrErr && !storeOut.valid)
		else $error("odd store accepted");
	a_store_addr: assert property (
		isHalfStore && !ea[0] |=> storeOut.valid && storeOut.vaddr == $past(ea))
		else $error("store address wrong");
	a_lane_pick: assert property (
		isHalfStore && !ea[0] |=> storeOut.byteEn == ($past(up) ? 4'hc : 4'h3))
		else $error("store lanes wrong");
	a_break_idiom: assert property (
		issue.valid && issue.instr == 32'h40 |=> excOut.issueBreak && !wbOut.valid)
		else $error("issue break idiom wrong");
	a_absent_user: assert property (
		isUserStore && !enhancedVaddrPresentBit |=> excOut.resInstr && !storeOut.valid)
		else $error("user store without enhanced bit");
	a_user_kernel: assert property (
		isUserStore && !issue.kernelMode |=> excOut.resInstr)
		else $error("user store outside kernel");
	a_user_map: assert property (
		isUserStore && enhancedVaddrPresentBit && issue.kernelMode
		&& issue.segMode == SEG_MAP_USER_KERN
		&& !ea9[0] |=> storeOut.valid && storeOut.userMap && storeOut.vaddr == $past(ea9))
		else $error("user store mapping wrong");
	c_store: cover property (storeOut.valid && storeOut.userMap);
	c_addr_err: cover property (excOut.addrErr);
	c_break: cover property (excOut.issueBreak);
endmodule
bind iscs_unit iscs_unit_chk chk(.clk(clk), .rst_n(rst_n),
	.enhancedVaddrPresentBit(enhancedVaddrPresentBit), .bigEndianConfig(bigEndianConfig),
	.endianSwapMode(endianSwapMode), .issue(issue), .wbOut(wbOut), .storeOut(storeOut),
	.excOut(excOut));

// >>> int_shift_compare_store_unit_test.sv
/* Random self-checking bench for the unit.
 Assumes one-cycle answer to every issue. */
`timescale 1ns/1ps
module int_shift_compare_store_unit_test;
	import iscs_pkg::*;
	logic clk, rst_n, enh, big, swp;
	iscs_issue_s issue;
	iscs_wb_s wbOut, ew;
	iscs_store_s storeOut, es;
	iscs_exc_s excOut, ee;
	int err_count, n_checks;
	int seed = 32'h0215;
	logic [31:0] tmpl [10] = '{{OPC_SPECIAL, 20'h0, FN_SHL}, {OPC_SPECIAL, 20'h0, FN_SHLV},
		{OPC_SPECIAL, 20'h0, FN_SETLT}, {OPC_SPECIAL, 20'h0, FN_SETLTU},
		{OPC_SETLT_IMM, 26'h0}, {OPC_SETLTU_IMM, 26'h0}, {OPC_SHW, 26'h0},
		{OPC_SPECIAL3, 20'h0, FN_HALF_USER}, 32'h0, 32'h40};
	logic [31:0] msk [10] = '{32'h03ffffc0, 32'h03fff800, 32'h03fff800, 32'h03fff800,
		32'h03ffffff, 32'h03ffffff, 32'h03ffffff, 32'h03ffff80, 32'h0, 32'h0};
	iscs_unit dut(.clk(clk), .rst_n(rst_n), .enhancedVaddrPresentBit(enh),
		.bigEndianConfig(big), .endianSwapMode(swp), .issue(issue), .wbOut(wbOut),
		.storeOut(storeOut), .excOut(excOut));
	iscs_mem_model mem(.clk(clk), .rst_n(rst_n), .store(storeOut));
	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	task predict(input iscs_issue_s x);
		logic [31:0] im, a;
		logic [5:0] op, fn;
		logic ln;
		im = {{16{x.instr[15]}}, x.instr[15:0]};
		a = x.srcVal + im;
		op = x.instr[31:26];
		fn = x.instr[5:0];
		ew = '0;
		es = '0;
		ee = '0;
		if (!x.valid) return;
		if (op == OPC_SPECIAL && fn == FN_SHL && x.instr[20:7] == 14'h0) begin
			ee.issueBreak = x.instr[6];
		end else if (op == OPC_SPECIAL) begin
			ew = '{1'b1, x.instr[15:11], 32'h0};
			case (fn)
				FN_SHL: ew.value = x.tgtVal << x.instr[10:6];
				FN_SHLV: ew.value = x.tgtVal << x.srcVal[4:0];
				FN_SETLT: ew.value = 32'($signed(x.srcVal) < $signed(x.tgtVal));
				default: ew.value = 32'(x.srcVal < x.tgtVal);
			endcase
		end else if (op == OPC_SETLT_IMM) begin
			ew = '{1'b1, x.instr[20:16], 32'($signed(x.srcVal) < $signed(im))};
		end else if (op == OPC_SETLTU_IMM) begin
			ew = '{1'b1, x.instr[20:16], 32'(x.srcVal < im)};
		end else if (op == OPC_SPECIAL3 && (!enh || !x.kernelMode || x.segMode == 3'h0
			|| x.segMode > SEG_MAP_USER_KERN)) begin
			ee.resInstr = 1'b1;
		end else begin
			if (op == OPC_SPECIAL3)
				a = x.srcVal + {{23{x.instr[15]}}, x.instr[15:7]};
			ln = a[1] ^ big ^ swp;
			if (a[0])
				ee.addrErr = 1'b1;
			else
				es = '{1'b1, a, ln ? {x.tgtVal[15:0], 16'h0} : {16'h0, x.tgtVal[15:0]},
					ln ? 4'hc : 4'h3, op == OPC_SPECIAL3 && x.segMode == SEG_MAP_USER_KERN};
		end
	endtask
	// ----------------------------------------
	// Clock, watchdog, stimulus
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#15000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		rst_n = 1'b0;
		{enh, big, swp} = 3'h0;
		issue = '0;
		predict(issue);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk);
			issue.valid <= (i % 13 != 5);
			issue.instr <= tmpl[i % 10] | ($random(seed) & msk[i % 10]);
			issue.srcVal <= $random(seed);
			issue.tgtVal <= (i % 7 == 0) ? issue.srcVal : $random(seed);
			{issue.kernelMode, issue.segMode, enh, big, swp} <= 7'($random(seed));
			#1;
			check("wbv", wbOut.valid, ew.valid);
			if (ew.valid)
				check("wb", {wbOut.dest, wbOut.value}, {ew.dest, ew.value});
			check("stv", storeOut.valid, es.valid);
			if (es.valid)
				check("st", {storeOut.vaddr, storeOut.byteEn, storeOut.userMap, es.byteEn[3] ? storeOut.data[31:16] : storeOut.data[15:0]}, {es.vaddr, es.byteEn, es.userMap, es.byteEn[3] ? es.data[31:16] : es.data[15:0]});
			check("exc", excOut, ee);
			predict(issue);
		end
		tally_and_finish();
	end
endmodule
